// ===== rtl/gtz_regs.vh
// Constants for the gated event totalizer bank.
// Assumes inclusion by the counter channel and the bank top.
`ifndef GTZ_REGS_VH
`define GTZ_REGS_VH
`define GTZ_NUM_CH 4
`define GTZ_CNT_W 32
`define GTZ_FIRST_CH 6
`define GTZ_CLK_HZ 50000000
`define GTZ_MAX_RATE_HZ 1000000
`define GTZ_MIN_PERIOD_CYC (`GTZ_CLK_HZ / `GTZ_MAX_RATE_HZ)
`define GTZ_MIN_READS_PER_S 1000
`define GTZ_GATE_HIGH 2'h0
`define GTZ_GATE_LOW 2'h1
`define GTZ_GATE_NONE 2'h2
`define GTZ_EDGE_RISE 1'h0
`define GTZ_EDGE_FALL 1'h1
`define GTZ_RST_MANUAL 1'h0
`define GTZ_RST_READCLR 1'h1
`define GTZ_CNT_RESET 32'h00000000
`endif

// ===== rtl/gtz_channel.v
// One gated 32-bit totalizer channel with match and overflow alarm.
// Assumes event and gate inputs already synchronous to the clock.
`timescale 1ns/1ns
`include "gtz_regs.vh"
module gtz_channel (
  input wire i_clk,                 // System clock.
  input wire i_srst,                // Synchronous reset, active high.
  input wire i_ce,                  // Clock enable.
  input wire i_on,                  // Channel powered.
  input wire i_event,               // Event input level.
  input wire i_gate,                // Gate input level.
  input wire i_edge_sel,            // Counted edge polarity.
  input wire [1:0] i_gate_mode,     // Gate qualification mode.
  input wire i_rst_style,           // Manual or read-then-clear.
  input wire i_clear,               // Manual clear pulse.
  input wire i_read,                // Read request pulse.
  input wire [31:0] i_match,        // Match value.
  input wire i_match_en,            // Alarm on match.
  input wire i_ovf_en,              // Alarm on overflow.
  input wire i_ovf_clr,             // Clear sticky overflow.
  output reg [31:0] o_count,        // Live count.
  output reg [31:0] o_rdata,        // Captured readout.
  output reg o_rvalid,              // Readout valid pulse.
  output reg o_ovf,                 // Sticky overflow flag.
  output reg o_alarm                // Trigger alarm pulse.
);

  // ----------------------------------------
  // Edge and gate qualification
  // ----------------------------------------
  reg prev_event;
  wire rise = i_event & ~prev_event;
  wire fall = ~i_event & prev_event;
  wire edge_hit = (i_edge_sel == `GTZ_EDGE_FALL) ? fall : rise;
  reg gate_ok;
  // The gate is sampled in the same cycle as the edge; setup is left to
  // the source, which must settle the gate before the counted edge.
  always @* begin
    case (i_gate_mode)
      `GTZ_GATE_HIGH: gate_ok = i_gate;
      `GTZ_GATE_LOW: gate_ok = ~i_gate;
      default: gate_ok = 1'b1;
    endcase
  end
  wire tick = i_on & edge_hit & gate_ok;
  wire wrap = tick & (&o_count);
  wire do_rclr = i_read & (i_rst_style == `GTZ_RST_READCLR);

  // Next count after one counted event; all ones rolls over to zero.
  function [31:0] inc_count;
    input [31:0] value;
    begin
      inc_count = value + 32'h00000001;
    end
  endfunction

  // ----------------------------------------
  // Count, readout and flags
  // ----------------------------------------
  // A tick in the read-clear cycle is kept as a count of one so that no
  // event falls between capture and clear.
  always @(posedge i_clk) begin
    if (i_srst) begin
      prev_event <= 1'b0;
      o_count <= `GTZ_CNT_RESET;
      o_rdata <= `GTZ_CNT_RESET;
      o_rvalid <= 1'b0;
      o_ovf <= 1'b0;
      o_alarm <= 1'b0;
    end else if (i_ce) begin
      prev_event <= i_event;
      o_rvalid <= i_read;
      if (i_read) begin
        o_rdata <= o_count;
      end
      if (i_clear || do_rclr) begin
        o_count <= {31'h00000000, tick};
      end else if (tick) begin
        o_count <= inc_count(o_count);
      end
      if (wrap) begin
        o_ovf <= 1'b1;
      end else if (i_ovf_clr) begin
        o_ovf <= 1'b0;
      end
      o_alarm <= (i_match_en & tick & ~i_clear & ~do_rclr &
        (inc_count(o_count) == i_match)) | (i_ovf_en & wrap);
    end
  end
endmodule

// ===== rtl/gtz_bank.v
// Bank of four gated event totalizers with alarms and group power.
// Assumes all inputs synchronous to I_CLK; controls arrive as plain ports.
//
// Summary of operation
// - Four independent 32-bit counters, each with own gate, up to 1 MHz.
// - Counter increments on rising or falling edge, chosen per counter.
// - Gate modes: count while gate high, while gate low, or always.
// - Clear by manual command or read-then-clear without losing events.
// - Readout answers every cycle, far above 1000 reads per second.
// - Channels six to nine raise trigger alarm on match or overflow.
// - Counters switch off as a group and do not count when off.
// - Counts exposed in parallel for scanning and pattern matching.
`timescale 1ns/1ns
`include "gtz_regs.vh"
module gtz_bank (
  input wire I_CLK,                 // 50 MHz clock.
  input wire I_SRST,                // Synchronous reset, active high.
  input wire I_CE,                  // Clock enable, freezes all state.
  input wire I_POWER_ON,            // Group power for all counters.
  input wire [3:0] I_EVENT,         // Event inputs, one per channel.
  input wire [3:0] I_GATE,          // Gate inputs, one per channel.
  input wire [3:0] I_EDGE_FALL,     // 1 counts falling edges.
  input wire [7:0] I_GATE_MODE,     // Two bits per channel.
  input wire [3:0] I_READ_CLEAR,    // 1 selects read-then-clear.
  input wire [3:0] I_CLEAR,         // Manual clear pulses.
  input wire I_READ,                // Read request pulse.
  input wire [1:0] I_READ_SEL,      // Channel index to read.
  input wire [127:0] I_MATCH,       // Match values, 32 bits each.
  input wire [3:0] I_MATCH_EN,      // Alarm on match enables.
  input wire [3:0] I_OVF_EN,        // Alarm on overflow enables.
  input wire [3:0] I_OVF_CLR,       // Sticky overflow clear pulses.
  output reg [31:0] O_RDATA,        // Readout of selected channel.
  output reg O_RVALID,              // Readout valid pulse.
  output wire [127:0] O_COUNT,      // Live counts for scanning.
  output wire [3:0] O_OVF,          // Sticky overflow flags.
  output wire [3:0] O_ALARM,        // Alarm pulses, channels six to nine.
  output wire O_TRIGGER             // Any alarm this cycle.
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Picks one 32-bit word out of a flat four-word bus. The match values
  // and the captured readouts share this slicing, so one function keeps
  // the channel order the same on every bus.
  function [31:0] word_of;
    input [127:0] bus;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: word_of = bus[31:0];
        2'h1: word_of = bus[63:32];
        2'h2: word_of = bus[95:64];
        default: word_of = bus[127:96];
      endcase
    end
  endfunction

  // Picks the two-bit gate mode of one channel out of the packed field.
  function [1:0] mode_of;
    input [7:0] modes;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: mode_of = modes[1:0];
        2'h1: mode_of = modes[3:2];
        2'h2: mode_of = modes[5:4];
        default: mode_of = modes[7:6];
      endcase
    end
  endfunction

  // ----------------------------------------
  // Read strobe decode
  // ----------------------------------------
  // Only the addressed channel sees the read, so a read-then-clear on one
  // counter never disturbs the other three.
  reg [3:0] read_hit;
  always @* begin
    case (I_READ_SEL)
      2'h0: read_hit = {3'h0, I_READ};
      2'h1: read_hit = {2'h0, I_READ, 1'h0};
      2'h2: read_hit = {1'h0, I_READ, 2'h0};
      default: read_hit = {I_READ, 3'h0};
    endcase
  end

  // ----------------------------------------
  // Channel array
  // ----------------------------------------
  // All four channels share clock, reset, enable and group power; the
  // power line stops counting only, so a switched-off bank still answers
  // reads and clears.
  wire [127:0] rdata;
  wire [3:0] rvalid;

  // First counter, reported as channel six; its alarm is O_ALARM[0].
  gtz_channel u_ch0 (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_ce(I_CE),
    .i_on(I_POWER_ON),
    .i_event(I_EVENT[0]),
    .i_gate(I_GATE[0]),
    .i_edge_sel(I_EDGE_FALL[0]),
    .i_gate_mode(mode_of(I_GATE_MODE, 2'h0)),
    .i_rst_style(I_READ_CLEAR[0]),
    .i_clear(I_CLEAR[0]),
    .i_read(read_hit[0]),
    .i_match(word_of(I_MATCH, 2'h0)),
    .i_match_en(I_MATCH_EN[0]),
    .i_ovf_en(I_OVF_EN[0]),
    .i_ovf_clr(I_OVF_CLR[0]),
    .o_count(O_COUNT[31:0]),
    .o_rdata(rdata[31:0]),
    .o_rvalid(rvalid[0]),
    .o_ovf(O_OVF[0]),
    .o_alarm(O_ALARM[0])
  );

  // Second counter, reported as channel seven.
  gtz_channel u_ch1 (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_ce(I_CE),
    .i_on(I_POWER_ON),
    .i_event(I_EVENT[1]),
    .i_gate(I_GATE[1]),
    .i_edge_sel(I_EDGE_FALL[1]),
    .i_gate_mode(mode_of(I_GATE_MODE, 2'h1)),
    .i_rst_style(I_READ_CLEAR[1]),
    .i_clear(I_CLEAR[1]),
    .i_read(read_hit[1]),
    .i_match(word_of(I_MATCH, 2'h1)),
    .i_match_en(I_MATCH_EN[1]),
    .i_ovf_en(I_OVF_EN[1]),
    .i_ovf_clr(I_OVF_CLR[1]),
    .o_count(O_COUNT[63:32]),
    .o_rdata(rdata[63:32]),
    .o_rvalid(rvalid[1]),
    .o_ovf(O_OVF[1]),
    .o_alarm(O_ALARM[1])
  );

  // Third counter, reported as channel eight.
  gtz_channel u_ch2 (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_ce(I_CE),
    .i_on(I_POWER_ON),
    .i_event(I_EVENT[2]),
    .i_gate(I_GATE[2]),
    .i_edge_sel(I_EDGE_FALL[2]),
    .i_gate_mode(mode_of(I_GATE_MODE, 2'h2)),
    .i_rst_style(I_READ_CLEAR[2]),
    .i_clear(I_CLEAR[2]),
    .i_read(read_hit[2]),
    .i_match(word_of(I_MATCH, 2'h2)),
    .i_match_en(I_MATCH_EN[2]),
    .i_ovf_en(I_OVF_EN[2]),
    .i_ovf_clr(I_OVF_CLR[2]),
    .o_count(O_COUNT[95:64]),
    .o_rdata(rdata[95:64]),
    .o_rvalid(rvalid[2]),
    .o_ovf(O_OVF[2]),
    .o_alarm(O_ALARM[2])
  );

  // Fourth counter, reported as channel nine.
  gtz_channel u_ch3 (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_ce(I_CE),
    .i_on(I_POWER_ON),
    .i_event(I_EVENT[3]),
    .i_gate(I_GATE[3]),
    .i_edge_sel(I_EDGE_FALL[3]),
    .i_gate_mode(mode_of(I_GATE_MODE, 2'h3)),
    .i_rst_style(I_READ_CLEAR[3]),
    .i_clear(I_CLEAR[3]),
    .i_read(read_hit[3]),
    .i_match(word_of(I_MATCH, 2'h3)),
    .i_match_en(I_MATCH_EN[3]),
    .i_ovf_en(I_OVF_EN[3]),
    .i_ovf_clr(I_OVF_CLR[3]),
    .o_count(O_COUNT[127:96]),
    .o_rdata(rdata[127:96]),
    .o_rvalid(rvalid[3]),
    .o_ovf(O_OVF[3]),
    .o_alarm(O_ALARM[3])
  );

  // ----------------------------------------
  // Trigger merge
  // ----------------------------------------
  // Alarms from any channel merge onto one trigger line. It is left
  // combinational so the trigger leaves in the same cycle as the alarm.
  assign O_TRIGGER = |O_ALARM;

  // ----------------------------------------
  // Readout mux
  // ----------------------------------------
  // A read sampled at one edge is captured by its channel at that edge
  // and reaches O_RDATA with O_RVALID at the next, two edges in all.
  // The select is held one cycle so the mux picks the channel whose
  // capture just landed, which lets reads follow back to back.
  reg [1:0] read_sel;
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      read_sel <= 2'h0;
      O_RDATA <= `GTZ_CNT_RESET;
      O_RVALID <= 1'b0;
    end else if (I_CE) begin
      read_sel <= I_READ_SEL;
      O_RVALID <= |rvalid;
      if (|rvalid) begin
        O_RDATA <= word_of(rdata, read_sel);
      end
    end
  end
endmodule

// ===== verification/gtz_bank_sva.sv
// Port assertions for the totalizer bank.
// Assumes it is bound into gtz_bank; one clock domain.
`timescale 1ns/1ns
module gtz_bank_sva (
  input wire I_CLK,                 // Clock.
  input wire I_SRST,                // Reset, active high.
  input wire I_CE,                  // Clock enable.
  input wire I_POWER_ON,            // Group power.
  input wire I_READ,                // Read request.
  input wire O_RVALID,              // Readout valid.
  input wire O_TRIGGER,             // Merged trigger.
  input wire [3:0] I_GATE,          // Gate levels.
  input wire [3:0] I_CLEAR,         // Manual clears.
  input wire [3:0] I_MATCH_EN,      // Match alarm enables.
  input wire [3:0] I_OVF_EN,        // Overflow alarm enables.
  input wire [3:0] I_OVF_CLR,       // Overflow clears.
  input wire [3:0] O_OVF,           // Sticky overflow flags.
  input wire [3:0] O_ALARM,         // Alarm pulses.
  input wire [7:0] I_GATE_MODE,     // Gate modes.
  input wire [127:0] O_COUNT        // Live counts.
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  // Each ties an output to its cause; read clears land a cycle late.
  chk_trig_any: assert property (O_TRIGGER == |O_ALARM)
    else $error("trigger differs from alarms");
  chk_alarm_cause: assert property (O_ALARM != 4'h0 |->
    (O_ALARM & ~$past(I_MATCH_EN | I_OVF_EN)) == 4'h0) else $error("alarm");
  chk_off_frozen: assert property (!I_POWER_ON && I_CLEAR == 4'h0 &&
    !I_READ && !$past(I_READ) && !$past(I_READ, 2) |=> $stable(O_COUNT))
    else $error("counted while off");
  chk_read_lat: assert property (I_READ && I_CE ##1 I_CE |=> O_RVALID)
    else $error("read answer late");
  chk_rvalid_src: assert property (O_RVALID |-> $past(I_READ, 2))
    else $error("spurious read answer");
  chk_ovf_sticky: assert property (
    ($past(O_OVF) & ~O_OVF & ~$past(I_OVF_CLR)) == 4'h0) else $error("ovf");
  chk_count_step: assert property (O_COUNT[31:0] <= 32'h1 ||
    O_COUNT[31:0] - $past(O_COUNT[31:0]) <= 32'h1) else $error("step");
  chk_gate_block: assert property (I_GATE_MODE[1:0] == 2'h0 &&
    !I_GATE[0] && I_CLEAR == 4'h0 && !I_READ && !$past(I_READ)
    |=> O_COUNT[31:0] == $past(O_COUNT[31:0])) else $error("gated count");
endmodule
bind gtz_bank gtz_bank_sva i_sva (.I_CLK(I_CLK), .I_SRST(I_SRST),
  .I_CE(I_CE), .I_POWER_ON(I_POWER_ON), .I_READ(I_READ),
  .O_RVALID(O_RVALID), .O_TRIGGER(O_TRIGGER), .I_GATE(I_GATE),
  .I_CLEAR(I_CLEAR), .I_MATCH_EN(I_MATCH_EN), .I_OVF_EN(I_OVF_EN),
  .I_OVF_CLR(I_OVF_CLR), .O_OVF(O_OVF), .O_ALARM(O_ALARM),
  .I_GATE_MODE(I_GATE_MODE), .O_COUNT(O_COUNT));

// ===== verification/gtz_src.sv
// Pulse source standing in for the external event lines.
// Assumes a 50 MHz clock; lines idle low between pulses.
`timescale 1ns/1ns
module gtz_src (
  input wire i_clk,                 // Clock.
  input wire i_go,                  // Start one pulse.
  input wire [3:0] i_mask,          // Lines to pulse.
  output reg [3:0] o_event = 4'h0   // Event lines.
);
  reg [5:0] cnt = 6'h0;
  // 500 ns high, 1 us period, so the rate never beats 1 MHz.
  always @(posedge i_clk) begin
    if (i_go || cnt != 6'h0) cnt <= (cnt == 6'h31) ? 6'h0 : cnt + 6'h1;
    o_event <= (i_go || (cnt != 6'h0 && cnt < 6'h19)) ? i_mask : 4'h0;
  end
endmodule

// ===== verification/gated_event_totalizer_tb.sv
// Self-checking bench for the totalizer bank.
// Assumes gtz_src drives the event lines.
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module gated_event_totalizer_tb;
  reg I_CLK = 1'h0, I_SRST = 1'h1, I_CE = 1'h1, I_POWER_ON = 1'h1;
  reg I_READ = 1'h0, go = 1'h0;
  reg [3:0] I_GATE = 4'h0, I_EDGE_FALL = 4'h0, I_READ_CLEAR = 4'hf;
  reg [3:0] I_CLEAR = 4'h0, I_MATCH_EN = 4'h0, I_OVF_EN = 4'h0;
  reg [3:0] I_OVF_CLR = 4'h0, mask = 4'h0;
  reg [7:0] I_GATE_MODE = 8'h0;
  reg [1:0] I_READ_SEL = 2'h0;
  reg [127:0] I_MATCH = 128'h0;
  wire [31:0] O_RDATA;
  wire O_RVALID, O_TRIGGER;
  wire [127:0] O_COUNT;
  wire [3:0] O_OVF, O_ALARM, ev;
  int bad_count = 0, checks_done = 0, cyc = 0, alarms = 0, c, m, e, g, n;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  gtz_src i_src (.i_clk(I_CLK), .i_go(go), .i_mask(mask), .o_event(ev));
  gtz_bank i_dut (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_CE(I_CE),
    .I_POWER_ON(I_POWER_ON), .I_EVENT(ev), .I_GATE(I_GATE),
    .I_EDGE_FALL(I_EDGE_FALL), .I_GATE_MODE(I_GATE_MODE),
    .I_READ_CLEAR(I_READ_CLEAR), .I_CLEAR(I_CLEAR), .I_READ(I_READ),
    .I_READ_SEL(I_READ_SEL), .I_MATCH(I_MATCH), .I_MATCH_EN(I_MATCH_EN),
    .I_OVF_EN(I_OVF_EN), .I_OVF_CLR(I_OVF_CLR), .O_RDATA(O_RDATA),
    .O_RVALID(O_RVALID), .O_COUNT(O_COUNT), .O_OVF(O_OVF),
    .O_ALARM(O_ALARM), .O_TRIGGER(O_TRIGGER));
  always #10 I_CLK = ~I_CLK;
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Each pulse takes the source's full 50-cycle period.
  task pulse(input int k);
    repeat (k) begin
      go <= 1'h1;
      @(posedge I_CLK) go <= 1'h0;
      repeat (50) @(posedge I_CLK);
    end
  endtask
  task rd(input logic [1:0] ch, input logic [31:0] x);
    I_READ_SEL <= ch;
    I_READ <= 1'h1;
    exp_q.push_back(x);
    @(posedge I_CLK) I_READ <= 1'h0;
    repeat (3) @(posedge I_CLK);
  endtask
  // Answers are matched in order; the cycle ceiling catches a hang.
  always @(posedge I_CLK) begin
    if (O_RVALID === 1'h1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hxxxxxxxx;
      `CHK(O_RDATA, exp_v)
    end
    if (O_ALARM[3] === 1'h1 && O_TRIGGER === 1'h1) alarms++;
    if (++cyc == 20000) begin bad_count++; print_verdict; end
  end
  initial begin
    void'($urandom(32'hb93b));
    repeat (2) @(posedge I_CLK);
    I_SRST <= 1'h0;
    for (c = 0; c < 4; c++) for (m = 0; m < 4; m++)
      for (e = 0; e < 2; e++) begin
      g = $urandom % 2;
      n = 1 + $urandom % 3;
      I_EDGE_FALL[c] <= e[0];
      I_GATE_MODE[2*c +: 2] <= m[1:0];
      I_GATE <= {4{g[0]}};
      mask <= 4'h1 << c;
      pulse(n);
      rd(c[1:0], (m >= 2 || g == (m == 0)) ? n : 0);
    end
    $display("edge and gate test done");
    I_POWER_ON <= 1'h0;
    pulse(2);
    rd(2'h3, 32'h0);
    I_POWER_ON <= 1'h1;
    I_READ_CLEAR <= 4'h0;
    pulse(2);
    `CHK(O_COUNT[127:96], 32'h2)
    rd(2'h3, 32'h2);
    rd(2'h3, 32'h2);
    I_CLEAR <= 4'h8;
    @(posedge I_CLK) I_CLEAR <= 4'h0;
    rd(2'h3, 32'h0);
    // Enable held low must freeze the channel: this pulse leaves no count.
    I_CE <= 1'h0;
    pulse(1);
    I_CE <= 1'h1;
    rd(2'h3, 32'h0);
    I_MATCH[127:96] <= 32'h1;
    I_MATCH_EN <= 4'h8;
    I_OVF_EN <= 4'hf;
    pulse(1);
    `CHK(alarms, 1)
    $display("power, clear and alarm test done");
    I_SRST <= 1'h1;
    repeat (2) @(posedge I_CLK);
    I_SRST <= 1'h0;
    @(posedge I_CLK);
    `CHK(O_COUNT, 128'h0)
    `CHK(O_OVF, 4'h0)
    pulse(1);
    rd(2'h3, 32'h1);
    `CHK(exp_q.size(), 0)
    $display("reset and restart test done");
    print_verdict;
  end
endmodule
